/* File: rtl/rxerr_regs.sv */
// Error-position, signal-strength/oscillator and test registers
// Summary of operation
// [RULE1] Error position clears on reset and read
// [RULE2] Eight-bit error position, bit 7 MSB
// [RULE3] Load bit position on receive error
// [RULE4] Two upper position bits, cleared on read
// [RULE5] Bit 6 flags stable crystal oscillator
// [RULE6] Aux strength bits 5:3, swappable input
// [RULE7] Main strength bits 2:0 from input one
// [RULE8] Strength valid reception start to transmit
// [RULE9] Strength latches the reception peak
// [RULE10] Strength cleared when transmission begins
// [RULE11] Three-bit strength code, seven steps
// [RULE12] Carrier amplitude during RF-level command
// [RULE13] Test register resets to zero
// [RULE14] Bit 7: keying pin feeds decoder
// [RULE15] Bit 6: modulation pin outputs subcarrier
// [RULE16] Bit 5: direct modulation with rx reset
// [RULE17] Bit 4 selects amplifier stage output
// [RULE18] Bit 3 cuts second stage gain
// [RULE19] Bit 2 cuts first stage gain
// [RULE20] Bit 0 shows gain level on main
module rxerr_regs #(
    parameter int OSC_CYC = rxerr_pkg::OSC_SETTLE_CYC
) (
    input  wire logic               sys_clk,        // 10 MHz clock
    input  wire logic               nrst,           // Sync reset, low
    input  wire logic               enable,         // Chip enable, low clears
    input  wire rxerr_pkg::rxerr_req_t req,         // Host register access
    output logic [7:0]              rdata,          // Read data
    output logic                    rvalid,         // Read data valid pulse
    input  wire logic               err_event,      // Receive error pulse
    input  wire logic [9:0]         err_bit_pos,    // Bit position of error
    input  wire logic               osc_running,    // Oscillator started
    input  wire logic               rx_start,       // Reception start pulse
    input  wire logic               tx_start,       // Transmission start pulse
    input  wire logic               swap_inputs,    // Channel-swap control
    input  wire logic               rf_level_cmd,   // RF amplitude command
    input  wire logic [2:0]         env_level_one,  // Envelope, input one
    input  wire logic [2:0]         env_level_two,  // Envelope, input two
    input  wire logic [2:0]         carrier_level,  // Carrier amplitude
    input  wire logic [2:0]         agc_level,      // Gain control level
    output logic [1:0]              err_pos_upper,  // Position bits 9:8
    output logic                    strength_valid, // Strength values valid
    output rxerr_pkg::rxerr_test_t  test_ctrl       // Test controls
);
    logic        clr;
    logic [7:0]  err_pos_ff;
    logic [1:0]  err_up_ff;
    logic [7:0]  test_ff;
    logic [2:0]  main_ff;
    logic [2:0]  aux_ff;
    logic        valid_ff;
    logic        osc_ok_ff;
    logic [31:0] osc_cnt_ff;
    logic        osc_s1_ff;
    logic        osc_s2_ff;
    logic [7:0]  rdata_ff;
    logic        rvalid_ff;
    logic [2:0]  src_one;
    logic [2:0]  src_two;
    logic [2:0]  main_src;
    logic [2:0]  aux_src;
    logic [2:0]  main_view;
    logic        rd_err;
    logic        rd_mask;
    logic        enable_s1_ff;
    logic        enable_s2_ff;

    assign clr      = !nrst || !enable_s2_ff;
    assign rd_err   = req.rd && (req.addr == rxerr_pkg::ADDR_ERR_POS);
    // Upper position bits clear on a read of the mask register one below; that address reads 0x00
    assign rd_mask  = req.rd && (req.addr == rxerr_pkg::ADDR_ERR_POS - 8'h01);
    assign src_one  = rf_level_cmd ? carrier_level : env_level_one; // RULE12
    assign src_two  = rf_level_cmd ? carrier_level : env_level_two; // RULE12
    assign main_src = src_one;                                      // RULE7
    assign aux_src  = swap_inputs ? src_one : src_two;              // RULE6
    assign main_view = test_ff[rxerr_pkg::BIT_AGC_OBS] ? agc_level
                                                       : main_ff;  // RULE20

    // A new error outranks the clear from a read in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (clr)
            err_pos_ff <= rxerr_pkg::ERR_POS_RESET;                 // RULE1
        else if (err_event)
            err_pos_ff <= err_bit_pos[7:0];                         // RULE3 RULE2
        else if (rd_err)
            err_pos_ff <= rxerr_pkg::ERR_POS_RESET;                 // RULE1
    end

    always_ff @(posedge sys_clk)
    begin
        if (clr)
            err_up_ff <= 2'h0;
        else if (err_event)
            err_up_ff <= err_bit_pos[9:8];                          // RULE4
        else if (rd_mask)
            err_up_ff <= 2'h0;                                      // RULE4
    end

    always_ff @(posedge sys_clk)
    begin
        if (clr)
            test_ff <= rxerr_pkg::TEST_RESET;                       // RULE13
        else if (req.wr && req.addr == rxerr_pkg::ADDR_TEST)
            test_ff <= req.wdata;
    end

    // Peak hold; transmit start restarts the measurement
    always_ff @(posedge sys_clk)
    begin
        if (clr || tx_start)
        begin
            main_ff  <= rxerr_pkg::LEVEL_ZERO;                      // RULE10
            aux_ff   <= rxerr_pkg::LEVEL_ZERO;                      // RULE10
            valid_ff <= 1'b0;                                       // RULE8
        end
        else
        begin
            if (rx_start)
                valid_ff <= 1'b1;                                   // RULE8
            if (main_src > main_ff)
                main_ff <= main_src;                                // RULE9 RULE11
            if (aux_src > aux_ff)
                aux_ff <= aux_src;                                  // RULE9 RULE11
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
        end
        else
        begin
            osc_s1_ff <= osc_running;
            osc_s2_ff <= osc_s1_ff;
        end
    end

    // Chip enable is a pin: two stages before the clear logic sees it
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            enable_s1_ff <= 1'b1;
            enable_s2_ff <= 1'b1;
        end
        else
        begin
            enable_s1_ff <= enable;
            enable_s2_ff <= enable_s1_ff;
        end
    end

    // Settle timer; restarts whenever the oscillator drops
    always_ff @(posedge sys_clk)
    begin
        if (clr || !osc_s2_ff)
        begin
            osc_cnt_ff <= 32'h0;
            osc_ok_ff  <= 1'b0;
        end
        else if (osc_cnt_ff >= 32'(OSC_CYC - 1))
            osc_ok_ff  <= 1'b1;                                     // RULE5
        else
            osc_cnt_ff <= osc_cnt_ff + 32'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= req.rd;
            case (req.addr)
                rxerr_pkg::ADDR_ERR_POS:  rdata_ff <= err_pos_ff;
                rxerr_pkg::ADDR_STRENGTH:
                    rdata_ff <= {1'b0, osc_ok_ff, aux_ff, main_view};
                rxerr_pkg::ADDR_TEST:     rdata_ff <= test_ff;
                default:                  rdata_ff <= 8'h00;
            endcase
        end
    end

    assign rdata          = rdata_ff;
    assign rvalid         = rvalid_ff;
    assign err_pos_upper  = err_up_ff;
    assign strength_valid = valid_ff;
    // One driver for the whole bundle, so no field has two sources
    assign test_ctrl = '{
        keying_pin_decoder_input:
            test_ff[rxerr_pkg::BIT_KEY_IN],                 // RULE14
        modulation_pin_subcarrier_out:
            test_ff[rxerr_pkg::BIT_SUBC_OUT],               // RULE15
        direct_modulation_rx_reset:
            test_ff[rxerr_pkg::BIT_DIRECT],                 // RULE16
        stage_select:
            test_ff[rxerr_pkg::BIT_STAGE_SEL],              // RULE17
        second_stage_gain_cut:
            test_ff[rxerr_pkg::BIT_CUT2],                   // RULE18
        first_stage_gain_cut:
            test_ff[rxerr_pkg::BIT_CUT1],                   // RULE19
        follower_test:
            test_ff[rxerr_pkg::BIT_FOLLOW],
        gain_control_observe:
            test_ff[rxerr_pkg::BIT_AGC_OBS]
    };

    property p_err_load;
        @(posedge sys_clk) disable iff (clr)
        err_event |=> err_pos_ff == $past(err_bit_pos[7:0]);
    endproperty
    a_err_load: assert property (p_err_load) // RULE3
        else $error("error position not loaded");

    property p_err_rdclr;
        @(posedge sys_clk) disable iff (clr)
        rd_err && !err_event |=> err_pos_ff == 8'h00;
    endproperty
    a_err_rdclr: assert property (p_err_rdclr) // RULE1
        else $error("error position not cleared on read");

    property p_up_rdclr;
        @(posedge sys_clk) disable iff (clr)
        rd_mask && !err_event |=> err_up_ff == 2'h0;
    endproperty
    a_up_rdclr: assert property (p_up_rdclr) // RULE4
        else $error("upper position bits not cleared");

    property p_tx_clear;
        @(posedge sys_clk) disable iff (clr)
        tx_start |=> main_ff == 3'h0 && aux_ff == 3'h0 && !valid_ff;
    endproperty
    a_tx_clear: assert property (p_tx_clear) // RULE10
        else $error("strength not cleared on transmit");

    property p_peak;
        @(posedge sys_clk) disable iff (clr)
        !tx_start |=> main_ff >= $past(main_ff) && main_ff >= $past(main_src);
    endproperty
    a_peak: assert property (p_peak) // RULE9
        else $error("main strength peak lost");

    property p_aux_swap;
        @(posedge sys_clk) disable iff (clr)
        !tx_start && swap_inputs |=> aux_ff >= $past(src_one);
    endproperty
    a_aux_swap: assert property (p_aux_swap) // RULE6
        else $error("aux channel ignores swap");

    property p_valid;
        @(posedge sys_clk) disable iff (clr)
        rx_start && !tx_start |=> valid_ff;
    endproperty
    a_valid: assert property (p_valid) // RULE8
        else $error("strength not valid after rx start");

    property p_osc;
        @(posedge sys_clk) disable iff (clr)
        $rose(osc_ok_ff) |-> $past(osc_s2_ff)
            && osc_cnt_ff == 32'(OSC_CYC - 1);
    endproperty
    a_osc: assert property (p_osc) // RULE5
        else $error("oscillator flag early");

    property p_agc_obs;
        @(posedge sys_clk) disable iff (clr)
        req.rd && req.addr == rxerr_pkg::ADDR_STRENGTH
            && test_ff[rxerr_pkg::BIT_AGC_OBS] |=> rdata_ff[2:0] == $past(agc_level);
    endproperty
    a_agc_obs: assert property (p_agc_obs) // RULE20
        else $error("gain level not observed");

    property p_clr_state;
        @(posedge sys_clk)
        clr |=> test_ff == rxerr_pkg::TEST_RESET
            && err_pos_ff == rxerr_pkg::ERR_POS_RESET;
    endproperty
    a_clr_state: assert property (p_clr_state) // RULE13
        else $error("registers not cleared by reset or enable");

    property p_osc_drop;
        @(posedge sys_clk) disable iff (clr)
        !osc_s2_ff |=> !osc_ok_ff;
    endproperty
    a_osc_drop: assert property (p_osc_drop) // RULE5
        else $error("oscillator flag kept while oscillator down");

    property p_main_env;
        @(posedge sys_clk) disable iff (clr)
        !tx_start && !rf_level_cmd |=> main_ff >= $past(env_level_one);
    endproperty
    a_main_env: assert property (p_main_env) // RULE7
        else $error("main strength misses input one");

    property p_carrier;
        @(posedge sys_clk) disable iff (clr)
        !tx_start && rf_level_cmd |=> main_ff >= $past(carrier_level);
    endproperty
    a_carrier: assert property (p_carrier) // RULE12
        else $error("main strength misses carrier level");

    c_err_read: cover property (@(posedge sys_clk) err_event ##[1:20] rd_err);
    c_rx_tx: cover property (@(posedge sys_clk) rx_start ##[1:50] tx_start);
    c_osc: cover property (@(posedge sys_clk) $rose(osc_ok_ff));
    c_swap: cover property (@(posedge sys_clk) swap_inputs && aux_src > aux_ff);
    c_agc: cover property (@(posedge sys_clk)
        req.rd && req.addr == rxerr_pkg::ADDR_STRENGTH
        && test_ff[rxerr_pkg::BIT_AGC_OBS]);
endmodule : rxerr_regs

/* File: include/rxerr_pkg.sv */
// Register map, field positions and timing constants for the status block
package rxerr_pkg;
    localparam logic [7:0] ADDR_ERR_POS   = 8'h0E;
    localparam logic [7:0] ADDR_STRENGTH  = 8'h0F;
    localparam logic [7:0] ADDR_TEST      = 8'h1A;
    localparam logic [7:0] ERR_POS_RESET  = 8'h00;
    localparam logic [7:0] TEST_RESET     = 8'h00;
    localparam logic [2:0] LEVEL_ZERO     = 3'h0;
    localparam logic [2:0] LEVEL_MAX      = 3'h7;
    localparam int         OSC_SETTLE_US  = 200;
    localparam int         CLK_MHZ        = 10;
    localparam int         OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;
    localparam int         BIT_OSC_OK     = 6;
    localparam int         BIT_KEY_IN     = 7;
    localparam int         BIT_SUBC_OUT   = 6;
    localparam int         BIT_DIRECT     = 5;
    localparam int         BIT_STAGE_SEL  = 4;
    localparam int         BIT_CUT2       = 3;
    localparam int         BIT_CUT1       = 2;
    localparam int         BIT_FOLLOW     = 1;
    localparam int         BIT_AGC_OBS    = 0;

    // Host register port request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rxerr_req_t;

    // Receiver analog/test controls driven from the test register
    typedef struct packed {
        logic keying_pin_decoder_input;
        logic modulation_pin_subcarrier_out;
        logic direct_modulation_rx_reset;
        logic stage_select;
        logic second_stage_gain_cut;
        logic first_stage_gain_cut;
        logic follower_test;
        logic gain_control_observe;
    } rxerr_test_t;
endpackage : rxerr_pkg

/* File: testbench/rxerr_host_model.sv */
// Host-side model that issues register reads and writes on the request port
module rxerr_host_model (
    input  wire logic              sys_clk, // Clock
    input  wire logic [7:0]        rdata,   // Read data
    input  wire logic              rvalid,  // Read data valid
    output rxerr_pkg::rxerr_req_t  req      // Register request
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;

    // Released fields show the inverse so a stale value cannot pass
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d,
                            output bit ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge sys_clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(posedge sys_clk);
            if (rvalid === 1'b1)
            begin
                d  = rdata;
                ok = 1'b1;
            end
        end
    endtask : reg_read
endmodule : rxerr_host_model

/* File: testbench/tb.sv */
// Self-checking bench for the status and test register block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, nrst = 1'b0, enable = 1'b1, err_event = 1'b0;
    logic osc_running = 1'b0, rx_start = 1'b0, tx_start = 1'b0;
    logic swap_inputs = 1'b0, rf_level_cmd = 1'b0;
    logic [9:0] err_bit_pos = 10'h000;
    logic [2:0] env_one = 3'h0, env_two = 3'h0, carrier = 3'h0, agc = 3'h0;
    logic [7:0] rdata;
    logic       rvalid, strength_valid;
    logic [1:0] err_pos_upper;
    logic [7:0] test_bits;
    rxerr_pkg::rxerr_req_t req;
    rxerr_pkg::rxerr_test_t test_ctrl;
    int mismatches = 0, total_checks = 0, cycles = 0;
    assign test_bits = test_ctrl;

    initial forever #50 sys_clk = ~sys_clk;

    rxerr_regs #(.OSC_CYC(20)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
        .enable(enable), .req(req), .rdata(rdata), .rvalid(rvalid),
        .err_event(err_event), .err_bit_pos(err_bit_pos),
        .osc_running(osc_running), .rx_start(rx_start),
        .tx_start(tx_start), .swap_inputs(swap_inputs),
        .rf_level_cmd(rf_level_cmd), .env_level_one(env_one),
        .env_level_two(env_two), .carrier_level(carrier),
        .agc_level(agc), .err_pos_upper(err_pos_upper),
        .strength_valid(strength_valid), .test_ctrl(test_ctrl));

    rxerr_host_model host_u (.sys_clk(sys_clk), .rdata(rdata),
        .rvalid(rvalid), .req(req));

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic rd(string nm, logic [7:0] a, logic [7:0] m,
                      logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        host_u.reg_read(a, d, ok);
        if (!ok)
            check({nm, " rvalid"}, 8'h00, 8'h01);
        check(nm, d & m, exp);
    endtask : rd

    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // Event pulses last one cycle: 0 error, 1 reception, 2 transmission
    task automatic pulse(int sel);
        @(posedge sys_clk);
        err_event <= (sel == 0);
        rx_start  <= (sel == 1);
        tx_start  <= (sel == 2);
        @(posedge sys_clk);
        {err_event, rx_start, tx_start} <= 3'h0;
    endtask : pulse

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        tick(20);
        nrst <= 1'b1;
        rd("errpos reset", 8'h0E, 8'hFF, 8'h00);
        rd("test reset", 8'h1A, 8'hFF, 8'h00);
        check("test_ctrl reset", test_bits, 8'h00);
        rd("osc early", 8'h0F, 8'h40, 8'h00);
        osc_running <= 1'b1;
        tick(30);
        rd("osc stable", 8'h0F, 8'h40, 8'h40);
        err_bit_pos <= 10'h2A5;
        pulse(0);
        tick(1);
        check("upper", {6'h00, err_pos_upper}, 8'h02);
        rd("errpos", 8'h0E, 8'hFF, 8'hA5);
        rd("errpos clr", 8'h0E, 8'hFF, 8'h00);
        rd("mask reg", 8'h0D, 8'hFF, 8'h00);
        tick(1);
        check("upper clr", {6'h00, err_pos_upper}, 8'h00);
        host_u.reg_write(8'h0E, 8'hFF);
        rd("errpos ro", 8'h0E, 8'hFF, 8'h00);
        rd("unmapped", 8'h30, 8'hFF, 8'h00);
        pulse(2);
        pulse(1);
        env_one <= 3'h3;
        env_two <= 3'h5;
        tick(3);
        env_one <= 3'h2;
        tick(3);
        check("valid", {7'h00, strength_valid}, 8'h01);
        rd("peak", 8'h0F, 8'hFF, 8'h6B);
        {env_one, env_two} <= 6'h00;
        pulse(2);
        tick(2);
        check("valid tx", {7'h00, strength_valid}, 8'h00);
        rd("tx clear", 8'h0F, 8'hFF, 8'h40);
        swap_inputs <= 1'b1;
        pulse(1);
        env_one <= 3'h6;
        env_two <= 3'h1;
        tick(3);
        rd("swapped", 8'h0F, 8'hFF, 8'h76);
        env_one <= 3'h7;
        tick(3);
        rd("max code", 8'h0F, 8'h07, 8'h07);
        {env_one, env_two, swap_inputs} <= 7'h00;
        pulse(2);
        rf_level_cmd <= 1'b1;
        carrier <= 3'h4;
        pulse(1);
        tick(3);
        rd("carrier", 8'h0F, 8'h07, 8'h04);
        rf_level_cmd <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            host_u.reg_write(8'h1A, 8'h01 << i);
            rd("test rw", 8'h1A, 8'hFF, 8'h01 << i);
            check("test_ctrl", test_bits, 8'h01 << i);
        end
        agc <= 3'h5;
        tick(2);
        rd("agc observe", 8'h0F, 8'h07, 8'h05);
        host_u.reg_write(8'h1A, 8'h3C);
        pulse(0);
        enable <= 1'b0;
        tick(2);
        enable <= 1'b1;
        rd("test en", 8'h1A, 8'hFF, 8'h00);
        rd("errpos en", 8'h0E, 8'hFF, 8'h00);
        close_out();
    end
endmodule : tb
